// File: design/bsp_pkg.sv
package bsp_pkg;

    // ----------------------------------------
    // Data path sizes
    // ----------------------------------------
    localparam int DATA_W = 16;
    localparam int FIFO_ENTRIES = 10;
    localparam logic [3:0] PTR_LAST = 4'h9;
    localparam logic [3:0] DEPTH_MAX_CODE = 4'h9;
    localparam logic [3:0] DEPTH_DEFAULT = 4'h1;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_16 = 4'hF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ----------------------------------------
    // Field encodings
    // ----------------------------------------
    localparam logic [1:0] WL_8BIT = 2'h0;
    localparam logic [1:0] TX_IRQ_OFF = 2'h0;
    localparam logic [1:0] TX_IRQ_EMPTY = 2'h1;
    localparam logic [1:0] TX_IRQ_UNDERFLOW = 2'h2;
    localparam logic [1:0] TX_IRQ_FULL = 2'h3;
    localparam logic [1:0] RX_IRQ_NOT_EMPTY = 2'h1;
    localparam logic [1:0] RX_IRQ_FULL = 2'h3;
    localparam int PRESC_W = 8;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        BSP_IDLE = 2'b01,
        BSP_RUN = 2'b10
    } bsp_state_type;

    // Codes above the last legal one fall back to one entry
    function automatic logic [3:0] depth_decode(input logic [3:0] code);
        if (code <= DEPTH_MAX_CODE) begin
            return 4'(code + 4'h1);
        end
        return DEPTH_DEFAULT;
    endfunction : depth_decode

endpackage : bsp_pkg

// File: design/bsp_fifo.sv
`timescale 1ns/100ps
module bsp_fifo (
    // Clock and reset
    input logic core_clk,
    input logic reset,
    // Fill side
    input logic wr_en,
    input logic [15:0] wr_data,
    // Drain side
    input logic rd_en,
    output logic [15:0] rd_data,
    // Programmed depth, 1 to 10
    input logic [3:0] depth,
    // Status
    output logic [3:0] count,
    output logic full,
    output logic not_empty
);

    logic [15:0] mem [bsp_pkg::FIFO_ENTRIES];
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;

    // ----------------------------------------
    // Storage, one write port per entry
    // ----------------------------------------
    for (genvar i = 0; i < bsp_pkg::FIFO_ENTRIES; i++) begin : g_entry
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                mem[i] <= bsp_pkg::WORD_ZERO;
            end else if (wr_en && wr_ptr == 4'(i)) begin
                mem[i] <= wr_data;
            end
        end
    end

    // ----------------------------------------
    // Pointers and fill level
    // ----------------------------------------
    // Pointers wrap on the physical size; depth only limits the fill level
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count <= 4'h0;
        end else begin
            if (wr_en) begin
                wr_ptr <= (wr_ptr == bsp_pkg::PTR_LAST) ? 4'h0 : 4'(wr_ptr + 4'h1);
            end
            if (rd_en) begin
                rd_ptr <= (rd_ptr == bsp_pkg::PTR_LAST) ? 4'h0 : 4'(rd_ptr + 4'h1);
            end
            if (wr_en && !rd_en) begin
                count <= 4'(count + 4'h1);
            end else if (rd_en && !wr_en) begin
                count <= 4'(count - 4'h1);
            end
        end
    end

    assign rd_data = mem[rd_ptr];
    assign full = count >= depth;
    assign not_empty = count != 4'h0;

endmodule : bsp_fifo

// File: design/bsp_prescaler.sv
`timescale 1ns/100ps
module bsp_prescaler (
    // Clock and reset
    input logic core_clk,
    input logic reset,
    // Control
    input logic run,
    input logic [7:0] divide,
    // One-cycle enable at each serial clock half period
    output logic tick
);

    logic [7:0] cnt;
    logic [7:0] top;

    // A divide of zero behaves as one so the clock never stalls
    assign top = (divide == 8'h00) ? 8'h00 : 8'(divide - 8'h01);
    assign tick = run && cnt == top;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt <= 8'h00;
        end else if (!run || tick) begin
            cnt <= 8'h00;
        end else begin
            cnt <= 8'(cnt + 8'h01);
        end
    end

endmodule : bsp_prescaler

// File: design/bsp_core.sv
// Behaviour
// RL1 - Separate ten by sixteen transmit and receive buffers
// RL2 - Eight or sixteen bit words, left justified
// RL3 - One shift register sends and receives together
// RL4 - Serial clock output as master, input as slave
// RL5 - Polarity and phase settings match on both ends
// RL6 - Phase picks first or second edge sampling
// RL7 - Serial clock idles at polarity level
// RL8 - Select falls after stable clock, held low
// RL9 - Slave clock at most one eighth system
// RL10 - Word end loads next transmit word
// RL11 - Transmit depth change waits for word end
// RL12 - Transmit full, not empty, empty, underflow flags
// RL13 - Transmit write clears underflow and its request
// RL14 - Source select picks transmit interrupt condition
// RL15 - Source codes: off, empty, underflow, full
// RL16 - Writes before enable are never sent
// RL17 - Eight bit receive lands in upper byte
// RL18 - Receive depth codes give one to ten
// RL19 - Not empty when any held; full at depth
// RL20 - One deep: store sets both, read clears
// RL21 - Store while full raises receive overflow
// RL22 - Overflowing word discarded, buffer kept
// RL23 - Enable sets empty; write starts master clock
// RL24 - Empty raised again as word enters shifter
// RL25 - Disable sets empty, clears received bit count
// RL26 - All enabled sources share one interrupt line
// RL27 - Empty on last word leaving; write clears
`timescale 1ns/100ps
module bsp_core (
    // Clock and reset
    input logic core_clk,
    input logic reset,
    // Configuration
    input logic block_enable,
    input logic master_select,
    input logic clk_pol,
    input logic clk_pha,
    input logic [1:0] word_length_sel,
    input logic [3:0] rx_depth_sel,
    input logic [3:0] tx_depth_sel,
    input logic [1:0] tx_irq_source_sel,
    input logic [1:0] rx_irq_source_sel,
    input logic rx_err_irq_en,
    input logic [7:0] clock_prescaler,
    // Transmit data port
    input logic tx_wr_valid,
    input logic [15:0] tx_wr_data,
    output logic tx_wr_ready,
    // Receive data port
    input logic rx_rd_req,
    output logic [15:0] rx_rd_data,
    // Status
    output logic tx_full_flag,
    output logic tx_not_empty_flag,
    output logic tx_empty_flag,
    output logic tx_underflow_flag,
    output logic rx_not_empty_flag,
    output logic rx_full_flag,
    output logic rx_overflow_flag,
    input logic rx_overflow_clr,
    output logic irq,
    // Serial pins
    input logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input logic ss_n_in
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    bsp_pkg::bsp_state_type state;
    logic [15:0] sreg;
    logic [3:0] bit_cnt;
    logic [3:0] last_bit;
    logic [3:0] tx_depth_act;
    logic [3:0] tx_count;
    logic [3:0] rx_count;
    logic [15:0] tx_head;
    logic [15:0] load_data;
    logic [15:0] rx_word;
    logic sclk_level, sclk_prev, ss_prev, dout, have_word;
    logic is8, tick, din, slave_sel, sclk_moved;
    logic lead, trail, sample_edge, shift_edge, word_end;
    logic m_start, s_start, load, load_act, tx_pop, tx_wr;
    logic rx_store, rx_rd, ovf_set, ufl_set, idle_ok, m_stop;
    logic tx_irq, rx_irq;

    // ----------------------------------------
    // Buffers and clock divider
    // ----------------------------------------
    bsp_fifo u_tx_fifo ( // RL1
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(tx_wr),
        .wr_data(tx_wr_data),
        .rd_en(tx_pop),
        .rd_data(tx_head),
        .depth(tx_depth_act),
        .count(tx_count),
        .full(tx_full_flag),
        .not_empty(tx_not_empty_flag)
    );

    bsp_fifo u_rx_fifo ( // RL1
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(rx_store),
        .wr_data(rx_word),
        .rd_en(rx_rd),
        .rd_data(rx_rd_data),
        .depth(bsp_pkg::depth_decode(rx_depth_sel)), // RL18
        .count(rx_count),
        .full(rx_full_flag), // RL19 RL20
        .not_empty(rx_not_empty_flag)
    );

    bsp_prescaler u_presc (
        .core_clk(core_clk),
        .reset(reset),
        .run(state == bsp_pkg::BSP_RUN),
        .divide(clock_prescaler),
        .tick(tick)
    );

    // ----------------------------------------
    // Serial clock edges
    // ----------------------------------------
    assign is8 = word_length_sel == bsp_pkg::WL_8BIT;
    assign last_bit = is8 ? bsp_pkg::LAST_BIT_8 : bsp_pkg::LAST_BIT_16; // RL2
    assign slave_sel = block_enable && !master_select && !ss_n_in; // RL8
    // No synchroniser here: the slave clock is slow enough to sample directly
    assign sclk_moved = slave_sel && sclk_in != sclk_prev; // RL9
    always_comb begin
        if (master_select) begin
            lead = block_enable && state == bsp_pkg::BSP_RUN && tick && sclk_level == clk_pol;
            trail = block_enable && state == bsp_pkg::BSP_RUN && tick && sclk_level != clk_pol;
        end else begin
            lead = sclk_moved && sclk_prev == clk_pol; // RL5
            trail = sclk_moved && sclk_prev != clk_pol;
        end
    end
    assign sample_edge = clk_pha ? trail : lead; // RL6
    assign shift_edge = clk_pha ? lead : trail; // RL6
    assign din = master_select ? miso_in : mosi_in;
    assign word_end = sample_edge && bit_cnt == last_bit;

    // ----------------------------------------
    // Load and buffer control
    // ----------------------------------------
    assign tx_wr_ready = block_enable && !tx_full_flag;
    assign tx_wr = tx_wr_valid && tx_wr_ready; // RL16
    assign m_start = block_enable && master_select && state == bsp_pkg::BSP_IDLE
        && tx_not_empty_flag; // RL23
    // A word preloaded at the last word end goes out first, not a fresh pop
    assign s_start = block_enable && !master_select && ss_prev && !ss_n_in && !have_word;
    assign load = m_start || s_start || word_end; // RL10
    assign load_act = load && (tx_not_empty_flag || !master_select);
    assign tx_pop = load && tx_not_empty_flag; // RL10
    assign ufl_set = load && !tx_not_empty_flag && !master_select; // RL12
    assign load_data = tx_not_empty_flag ? tx_head : bsp_pkg::WORD_ZERO;
    assign rx_word = is8 ? {sreg[6:0], din, bsp_pkg::BYTE_ZERO} : {sreg[14:0], din}; // RL17
    assign rx_store = word_end && !rx_full_flag; // RL21
    assign ovf_set = word_end && rx_full_flag; // RL22
    assign rx_rd = rx_rd_req && rx_not_empty_flag; // RL20
    assign idle_ok = master_select ? state == bsp_pkg::BSP_IDLE : ss_n_in;
    assign m_stop = trail && !(word_end ? tx_not_empty_flag : have_word);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_depth_act <= bsp_pkg::DEPTH_DEFAULT;
        end else if (idle_ok || word_end) begin
            tx_depth_act <= bsp_pkg::depth_decode(tx_depth_sel); // RL11
        end
    end

    // ----------------------------------------
    // Shift register and bit counter
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sreg <= bsp_pkg::WORD_ZERO;
        end else if (load_act) begin
            sreg <= load_data; // RL3
        end else if (sample_edge) begin
            sreg <= {sreg[14:0], din}; // RL3
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dout <= 1'b0;
        end else if (load_act) begin
            dout <= load_data[15]; // RL2
        end else if (shift_edge) begin
            dout <= sreg[15];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bit_cnt <= 4'h0;
        end else if (!block_enable || (!master_select && ss_n_in) || m_start) begin
            bit_cnt <= 4'h0; // RL25
        end else if (sample_edge) begin
            bit_cnt <= word_end ? 4'h0 : 4'(bit_cnt + 4'h1);
        end
    end

    // ----------------------------------------
    // Master sequencing
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= bsp_pkg::BSP_IDLE;
        end else begin
            unique case (state)
                bsp_pkg::BSP_IDLE: begin
                    if (m_start) begin
                        state <= bsp_pkg::BSP_RUN; // RL23
                    end
                end
                bsp_pkg::BSP_RUN: begin
                    if (!block_enable || !master_select || m_stop) begin
                        state <= bsp_pkg::BSP_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            have_word <= 1'b0;
        end else if (m_start) begin
            have_word <= 1'b1;
        end else if (word_end) begin
            have_word <= tx_not_empty_flag;
        end else if (!block_enable || (master_select && state == bsp_pkg::BSP_IDLE)) begin
            have_word <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sclk_level <= 1'b0;
        end else if (state != bsp_pkg::BSP_RUN) begin
            sclk_level <= clk_pol; // RL7
        end else if (tick) begin
            sclk_level <= !sclk_level;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sclk_prev <= 1'b0;
            ss_prev <= 1'b1;
        end else begin
            sclk_prev <= sclk_in;
            ss_prev <= ss_n_in;
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    assign sclk_out = sclk_level;
    assign sclk_oe = block_enable && master_select; // RL4
    assign mosi_out = dout;
    assign mosi_oe = block_enable && master_select;
    assign miso_out = dout;
    // Unselected slaves release the line so several can share it
    assign miso_oe = slave_sel;

    // ----------------------------------------
    // Sticky flags, set wins over clear except on empty, where a write beats the last pop
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_empty_flag <= 1'b1;
        end else if (!block_enable || (tx_pop && tx_count == 4'h1 && !tx_wr)) begin
            tx_empty_flag <= 1'b1; // RL24 RL25 RL27
        end else if (tx_wr) begin
            tx_empty_flag <= 1'b0; // RL23 RL27
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_underflow_flag <= 1'b0;
        end else if (ufl_set) begin
            tx_underflow_flag <= 1'b1; // RL12
        end else if (tx_wr) begin
            tx_underflow_flag <= 1'b0; // RL13
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_overflow_flag <= 1'b0;
        end else if (ovf_set) begin
            rx_overflow_flag <= 1'b1; // RL21
        end else if (rx_overflow_clr) begin
            rx_overflow_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    always_comb begin
        unique case (tx_irq_source_sel) // RL14 RL15
            bsp_pkg::TX_IRQ_OFF: tx_irq = 1'b0;
            bsp_pkg::TX_IRQ_EMPTY: tx_irq = tx_empty_flag;
            bsp_pkg::TX_IRQ_UNDERFLOW: tx_irq = tx_underflow_flag;
            bsp_pkg::TX_IRQ_FULL: tx_irq = tx_full_flag;
        endcase
    end
    always_comb begin
        rx_irq = 1'b0;
        if (rx_irq_source_sel == bsp_pkg::RX_IRQ_NOT_EMPTY) begin
            rx_irq = rx_not_empty_flag;
        end else if (rx_irq_source_sel == bsp_pkg::RX_IRQ_FULL) begin
            rx_irq = rx_full_flag;
        end
    end
    assign irq = tx_irq || rx_irq || (rx_err_irq_en && rx_overflow_flag); // RL26

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence seq_store_one_deep;
        rx_store && !rx_rd && bsp_pkg::depth_decode(rx_depth_sel) == 4'h1;
    endsequence
    sequence seq_store_full;
        word_end && rx_full_flag && !rx_rd;
    endsequence

    chk_rx_one_deep: assert property (seq_store_one_deep |=> rx_full_flag && rx_not_empty_flag) // RL20
        else $error("one deep store did not set both flags");
    chk_rx_overflow_set: assert property (seq_store_full |=> rx_overflow_flag // RL21
        && rx_count == $past(rx_count))
        else $error("overflow not flagged or buffer changed");
    chk_tx_write_clear: assert property (tx_wr && !ufl_set |=> !tx_underflow_flag) // RL13
        else $error("transmit write left underflow set");
    chk_tx_empty_clear: assert property (tx_wr && block_enable && !tx_pop |=> !tx_empty_flag) // RL27
        else $error("transmit write left empty flag set");
    chk_disable_empty: assert property ($fell(block_enable) |=> tx_empty_flag && bit_cnt == 4'h0) // RL25
        else $error("disable did not set empty or clear count");
    chk_load_on_end: assert property (word_end && tx_not_empty_flag && !tx_wr // RL10
        |=> tx_count == 4'($past(tx_count) - 4'h1))
        else $error("word end did not load next word");
    chk_byte_left: assert property (rx_store && is8 |-> rx_word[7:0] == bsp_pkg::BYTE_ZERO) // RL17
        else $error("byte word not left justified");
    chk_irq_merge: assert property (tx_irq_source_sel == bsp_pkg::TX_IRQ_EMPTY // RL26
        && tx_empty_flag |-> irq)
        else $error("enabled empty source missing on interrupt");
    chk_sclk_idle: assert property ((state == bsp_pkg::BSP_IDLE && $stable(clk_pol)) [*2] // RL7
        |-> sclk_out == clk_pol)
        else $error("serial clock not at idle level");
    chk_master_start: assert property (m_start |=> state == bsp_pkg::BSP_RUN // RL23
        ##0 !tx_empty_flag || tx_count == 4'h0 || tx_wr)
        else $error("master did not start on queued word");

endmodule : bsp_core

// File: dv/bsp_spi_partner.sv
`timescale 1ns/100ps
// ----------------------------------------
// External slave on the serial link
// ----------------------------------------
module bsp_spi_partner (
    // Serial pins
    input logic sclk,
    input logic mosi,
    output logic miso,
    // Mode, same as the device
    input logic pol,
    input logic pha,
    input logic [4:0] nbits,
    // Word exchange
    input logic load,
    input logic [15:0] tx_word,
    output logic [15:0] rx_word
);
    logic [15:0] shift;
    logic [4:0] cnt;

    // Phase one leaves the line unsettled until the first edge
    always @(posedge load) begin
        shift = tx_word;
        cnt = 5'h00;
        rx_word = 16'h0000;
        miso = pha ? ~tx_word[15] : tx_word[15];
    end

    // Leading edge samples for phase zero, trailing for phase one
    always @(sclk) begin
        if ((sclk !== pol) ^ pha) begin
            rx_word = {rx_word[14:0], mosi};
            cnt = cnt + 5'h01;
        end else if (pha) begin
            miso = shift[15];
            shift = shift << 1;
        end else begin
            shift = shift << 1;
            // Past the word the line carries nothing useful
            miso = (cnt < nbits) ? shift[15] : ~miso;
        end
    end
endmodule : bsp_spi_partner

// File: dv/tb_bsp_core.sv
`timescale 1ns/100ps
module tb_bsp_core;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk, reset, block_enable, master_select, clk_pol, clk_pha;
    logic [1:0] word_length_sel, tx_irq_source_sel, rx_irq_source_sel;
    logic [3:0] rx_depth_sel, tx_depth_sel;
    logic [7:0] clock_prescaler;
    logic [15:0] tx_wr_data, rx_rd_data, p_tx, p_rx, got;
    logic rx_err_irq_en, tx_wr_valid, tx_wr_ready, rx_rd_req, rx_overflow_clr, irq;
    logic tx_full_flag, tx_not_empty_flag, tx_empty_flag, tx_underflow_flag;
    logic rx_not_empty_flag, rx_full_flag, rx_overflow_flag, ss_n_in;
    logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, tb_sclk, tb_mosi;
    logic p_miso, p_load;
    logic [4:0] p_nbits;
    int bad_count, comparisons;
    wire sclk_pin = sclk_oe ? sclk_out : tb_sclk;
    wire mosi_pin = mosi_oe ? mosi_out : tb_mosi;
    wire miso_pin = miso_oe ? miso_out : p_miso;

    bsp_core u_dut (.core_clk(core_clk), .reset(reset), .block_enable(block_enable),
        .master_select(master_select), .clk_pol(clk_pol), .clk_pha(clk_pha),
        .word_length_sel(word_length_sel), .rx_depth_sel(rx_depth_sel),
        .tx_depth_sel(tx_depth_sel), .tx_irq_source_sel(tx_irq_source_sel),
        .rx_irq_source_sel(rx_irq_source_sel), .rx_err_irq_en(rx_err_irq_en),
        .clock_prescaler(clock_prescaler), .tx_wr_valid(tx_wr_valid),
        .tx_wr_data(tx_wr_data), .tx_wr_ready(tx_wr_ready), .rx_rd_req(rx_rd_req),
        .rx_rd_data(rx_rd_data), .tx_full_flag(tx_full_flag),
        .tx_not_empty_flag(tx_not_empty_flag), .tx_empty_flag(tx_empty_flag),
        .tx_underflow_flag(tx_underflow_flag), .rx_not_empty_flag(rx_not_empty_flag),
        .rx_full_flag(rx_full_flag), .rx_overflow_flag(rx_overflow_flag),
        .rx_overflow_clr(rx_overflow_clr), .irq(irq), .sclk_in(sclk_pin),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out), .miso_oe(miso_oe),
        .ss_n_in(ss_n_in));

    bsp_spi_partner u_partner (.sclk(sclk_pin), .mosi(mosi_pin), .miso(p_miso),
        .pol(clk_pol), .pha(clk_pha), .nbits(p_nbits), .load(p_load), .tx_word(p_tx),
        .rx_word(p_rx));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask : chk

    task automatic tx_write(input logic [15:0] d);
        tx_wr_data = d;
        tx_wr_valid = 1'b1;
        step(1);
        tx_wr_valid = 1'b0;
        step(1);
    endtask : tx_write

    task automatic rx_read();
        rx_rd_req = 1'b1;
        step(1);
        rx_rd_req = 1'b0;
    endtask : rx_read

    task automatic master_xfer(input int i, input logic [15:0] a, input logic [15:0] b);
        logic wide;
        int n;
        wide = (i != 3);
        clk_pol = 1'(i >> 1);
        clk_pha = 1'(i);
        word_length_sel = wide ? 2'h1 : bsp_pkg::WL_8BIT;
        rx_depth_sel = (i == 2) ? 4'hC : 4'h0;
        p_nbits = wide ? 5'h10 : 5'h08;
        p_tx = b;
        step(2);
        p_load = 1'b1;
        step(1);
        p_load = 1'b0;
        chk("sclk idle", 16'(clk_pol), 16'(sclk_out));
        tx_write(a);
        step(3);
        chk("tx empty", 16'h0001, 16'(tx_empty_flag));
        chk("irq", 16'h0001, 16'(irq));
        n = 0;
        while (rx_not_empty_flag !== 1'b1 && n < 500) begin
            step(1);
            n++;
        end
        step(12);
        chk("sclk idle", 16'(clk_pol), 16'(sclk_out));
        chk("far rx", wide ? a : {8'h00, a[15:8]}, p_rx);
        chk("rx data", wide ? b : {b[15:8], 8'h00}, rx_rd_data);
        chk("rx full", 16'h0001, 16'(rx_full_flag));
        rx_read();
        chk("rx not empty", 16'h0000, 16'(rx_not_empty_flag));
    endtask : master_xfer

    // The bench stands in for an external master, at one sixteenth of the core clock
    task automatic slave_xfer(input logic [15:0] m, output logic [15:0] seen);
        ss_n_in = 1'b0;
        step(8);
        for (int b = 15; b >= 0; b--) begin
            tb_mosi = m[b];
            step(8);
            tb_sclk = 1'b1;
            seen[b] = miso_pin;
            step(8);
            tb_sclk = 1'b0;
        end
        step(8);
        ss_n_in = 1'b1;
        tb_mosi = ~tb_mosi;
        step(8);
    endtask : slave_xfer

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {reset, block_enable, master_select, clk_pol, clk_pha, rx_err_irq_en} = 6'h21;
        {tx_wr_valid, rx_rd_req, rx_overflow_clr, tb_sclk, tb_mosi, p_load} = 6'h00;
        ss_n_in = 1'b1;
        word_length_sel = 2'h1;
        {rx_depth_sel, tx_depth_sel} = 8'h00;
        tx_irq_source_sel = bsp_pkg::TX_IRQ_EMPTY;
        rx_irq_source_sel = 2'h0;
        clock_prescaler = 8'h02;
        {tx_wr_data, p_tx, p_nbits} = 37'h0;
        repeat (20) @(posedge core_clk);
        #1;
        reset = 1'b0;
        chk("tx empty", 16'h0001, 16'(tx_empty_flag));
        tx_write(16'h1234);
        chk("tx not empty", 16'h0000, 16'(tx_not_empty_flag));
        master_select = 1'b1;
        block_enable = 1'b1;
        step(2);
        chk("tx empty", 16'h0001, 16'(tx_empty_flag));
        chk("sclk oe", 16'h0001, 16'(sclk_oe));
        chk("mosi oe", 16'h0001, 16'(mosi_oe));
        for (int i = 0; i < 4; i++) master_xfer(i, 16'hA5C3 ^ 16'(i), 16'h3C5A + 16'(i));
        block_enable = 1'b0;
        master_select = 1'b0;
        {clk_pol, clk_pha, rx_depth_sel, tx_depth_sel, word_length_sel} = 12'h009;
        step(2);
        block_enable = 1'b1;
        step(2);
        chk("sclk oe", 16'h0000, 16'(sclk_oe));
        for (int k = 0; k < 4; k++) tx_write(16'hC000 + 16'(k));
        chk("tx full", 16'h0001, 16'(tx_full_flag));
        chk("tx ready", 16'h0000, 16'(tx_wr_ready));
        for (int s = 0; s < 4; s++) begin
            tx_irq_source_sel = 2'(s);
            step(1);
            chk("irq source", 16'(s == 3), 16'(irq));
        end
        slave_xfer(16'h5A01, got);
        chk("slave tx", 16'hC000, got);
        chk("slave rx", 16'h5A01, rx_rd_data);
        slave_xfer(16'h5A02, got);
        chk("slave tx", 16'hC001, got);
        chk("rx overflow", 16'h0001, 16'(rx_overflow_flag));
        chk("rx kept", 16'h5A01, rx_rd_data);
        rx_err_irq_en = 1'b1;
        tx_irq_source_sel = bsp_pkg::TX_IRQ_OFF;
        step(1);
        chk("irq", 16'h0001, 16'(irq));
        rx_overflow_clr = 1'b1;
        step(1);
        rx_overflow_clr = 1'b0;
        step(1);
        chk("irq", 16'h0000, 16'(irq));
        rx_irq_source_sel = bsp_pkg::RX_IRQ_FULL;
        step(1);
        chk("irq", 16'h0001, 16'(irq));
        rx_read();
        chk("irq", 16'h0000, 16'(irq));
        rx_irq_source_sel = 2'h0;
        slave_xfer(16'h5A03, got);
        chk("slave tx", 16'hC002, got);
        chk("tx empty", 16'h0001, 16'(tx_empty_flag));
        rx_read();
        slave_xfer(16'h5A04, got);
        chk("tx underflow", 16'h0001, 16'(tx_underflow_flag));
        tx_irq_source_sel = bsp_pkg::TX_IRQ_UNDERFLOW;
        step(1);
        chk("irq", 16'h0001, 16'(irq));
        tx_write(16'hBEEF);
        step(1);
        chk("tx underflow", 16'h0000, 16'(tx_underflow_flag));
        chk("irq", 16'h0000, 16'(irq));
        block_enable = 1'b0;
        step(2);
        chk("tx empty", 16'h0001, 16'(tx_empty_flag));
        tally_and_finish();
    end
endmodule : tb_bsp_core
